// [rtl/sev_top.sv]
// Status event sources with pin mux, latched flags and AXI4-Lite registers
// What this block does
// - Async converter error high whenever any of its rates exceeds 48 kHz; pin code 1Ch
// - Rising edge of async converter error sets a latched, readable flag
// - Isochronous converter error on invalid rate combination; pin codes 4Dh, 4Eh, 4Fh
// - Each isochronous error rising edge sets its own latched flag
// - Separate overheat warning and shutdown levels, either selectable on a pin
// - Headphone channel shorted when its positive or negative indication is set
// - Overheat shutdown or speaker short disables the speaker drivers
// - Speaker shutdown status raised once driver shutdown completes; pin selectable
// - Temperature, short and speaker shutdown set flags on their edges
// - Compressor signal detect status on pins, codes 1Dh and 22h
// - Compressor anti-clip status on pins, codes 1Eh and 23h
// - Compressor decay status on pins, codes 1Fh and 24h
// - Compressor noise gate status on pins, codes 20h and 25h
// - Compressor quick release status on pins, codes 21h and 26h
// - Sequencer active flag reads one while any sequence runs or waits
// - Sequencer completion gives a 13-cycle pulse, 104 ns at 125 MHz, pin code 15h
// - Sequence completion sets the sequencer latched flag
// - Access to an invalid address fails and raises control error; pin 16h
// - Firmware memory access with its clock off fails as control error
// - Rising edge of control error sets its latched flag
// - Clock domain shutdown sets a flag; enable statuses on pins 4Bh, 4Ch
// - Latched flags stay set until the host writes one to them
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module sev_top #(
  parameter int NUM_PINS = 2
) (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic [11:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [11:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire sev_pkg::sev_prot_t       prot,
  input  wire sev_pkg::sev_drc_t        dynamic_range_compressor,
  input  wire logic                     seq_busy,
  input  wire logic                     main_clk_stopped,
  input  wire logic                     sec_clk_stopped,
  input  wire logic                     spk_drive_idle,
  output logic [NUM_PINS-1:0]           pin_out,
  output logic                          spk_drive_en,
  output logic                          main_clock_enable,
  output logic                          secondary_clock_enable,
  output logic                          fw_mem_clock_enable
);
  import sev_pkg::*;

  initial begin
    if (NUM_PINS < 1 || NUM_PINS > 4) $error("NUM_PINS must be 1 to 4");
  end

  // Compares a rate field against the async converter limit
  function automatic logic rate_over(input logic [7:0] khz);
    return khz > ASYNC_RATE_CONVERTER_MAX_KHZ;
  endfunction : rate_over

  // Byte-lane merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction : merge

  // Address decode: valid when it names a register or the firmware page
  function automatic logic addr_ok(input logic [11:0] a);
    return (a == ADDR_PIN_FN) || (a == ADDR_RATE) || (a == ADDR_ISOCHRONOUS_RATE_CONVERTER) || (a == ADDR_CLK) ||
           (a == ADDR_FLAGS) || (a == ADDR_RAW) || (a[11:4] == FW_PAGE);
  endfunction : addr_ok

  // Pin function decode; unknown codes drive low
  function automatic logic fn_level(input logic [7:0] c, input sev_src_t s);
    logic r;
    r = 1'b0;
    if (c >= FN_DRC1 && c < FN_DRC2) r = s.dynamic_range_compressor.drc1[3'(c - FN_DRC1)];
    else if (c >= FN_DRC2 && c < FN_DRC2 + 8'h05) r = s.dynamic_range_compressor.drc2[3'(c - FN_DRC2)];
    else if (c >= FN_ISOCHRONOUS_RATE_CONVERTER && c < FN_ISOCHRONOUS_RATE_CONVERTER + 8'h03) r = s.isochronous_rate_converter_err[2'(c - FN_ISOCHRONOUS_RATE_CONVERTER)];
    else if (c >= FN_HP_SHORT && c < FN_HP_SHORT + 8'h06) r = s.hp_short[3'(c - FN_HP_SHORT)];
    else begin
      case (c)
        FN_ASYNC_RATE_CONVERTER_ERR:  r = s.async_rate_converter_err;
        FN_TEMP_WARN: r = s.temp_warn;
        FN_TEMP_SHUT: r = s.temp_shut;
        FN_SPK_SHORT: r = s.spk_short;
        FN_SPK_SD:    r = s.spk_sd;
        FN_SEQ_DONE:  r = s.seq_done;
        FN_CTL_ERR:   r = s.ctl_err;
        FN_MAIN_CLK:  r = s.main_sts;
        FN_SEC_CLK:   r = s.sec_sts;
        default:      r = 1'b0;
      endcase
    end
    return r;
  endfunction : fn_level

  logic [31:0]          pin_fn_reg;
  logic [31:0]          rate_reg;
  logic [31:0]          isochronous_rate_converter_reg;
  logic [3:0]           clk_ctrl_reg;
  logic [31:0]          fw_mem [FW_WORDS];
  logic [NUM_FLAGS-1:0] flags_reg;
  logic [NUM_FLAGS-1:0] lvl_prev_reg;
  logic [NUM_FLAGS-1:0] lvl;
  logic [NUM_FLAGS-1:0] set_vec;
  logic [NUM_FLAGS-1:0] clr_vec;
  logic [11:0]          awaddr_reg;
  logic [31:0]          wdata_reg;
  logic [3:0]           wstrb_reg;
  logic                 wr_go;
  logic                 wr_ok;
  logic                 wr_fw;
  logic                 rd_go;
  logic                 rd_ok;
  logic                 rd_fw;
  logic [31:0]          rd_val;
  logic                 ctl_err_reg;
  logic                 spk_fault;
  logic                 spk_sd_reg;
  logic                 seq_busy_prev_reg;
  logic [4:0]           seq_cnt_reg;
  logic [2:0]           isochronous_rate_converter_bad;
  sev_src_t             src;

  // Isochronous combination check: fast-side code must not be below slow-side code
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      isochronous_rate_converter_bad[i] = isochronous_rate_converter_reg[8*i +: 4] < isochronous_rate_converter_reg[8*i+4 +: 4];
    end
  end

  // Speaker protection trips on overheat shutdown or a speaker short
  assign spk_fault = prot.temp_shut | (|prot.spk_short);

  // Gather every status level the pins and flags can see
  always_comb begin
    src.async_rate_converter_err  = rate_over(rate_reg[7:0]) | rate_over(rate_reg[15:8]);
    src.isochronous_rate_converter_err  = isochronous_rate_converter_bad;
    src.temp_warn = prot.temp_warn;
    src.temp_shut = prot.temp_shut;
    src.spk_short = |prot.spk_short;
    src.hp_short  = prot.hp_short_pos | prot.hp_short_neg;
    src.spk_sd    = spk_sd_reg;
    src.seq_done  = seq_cnt_reg != 5'h0;
    src.ctl_err   = ctl_err_reg;
    src.main_sts  = !main_clk_stopped;
    src.sec_sts   = !sec_clk_stopped;
    src.dynamic_range_compressor       = dynamic_range_compressor;
  end

  // Flag sources; clock statuses are inverted so shutdown is a rising edge
  assign lvl = {!src.sec_sts, !src.main_sts, src.ctl_err, src.seq_done, src.spk_sd, |src.hp_short,
                src.spk_short, src.temp_shut, src.temp_warn, src.isochronous_rate_converter_err, src.async_rate_converter_err};

  // Temperature flags catch both edges, the rest rising only
  assign set_vec = (lvl & ~lvl_prev_reg) | (BOTH_EDGES & (lvl ^ lvl_prev_reg));

  // Write-one-to-clear on the flag register
  assign clr_vec = (wr_go && awaddr_reg == ADDR_FLAGS) ? wdata_reg[NUM_FLAGS-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lvl_prev_reg <= '0;
    end else begin
      lvl_prev_reg <= lvl;
    end
  end

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~clr_vec) | set_vec;
    end
  end

  // Completion pulse: fixed cycle count from the falling edge of busy
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seq_busy_prev_reg <= 1'b0;
      seq_cnt_reg       <= 5'h0;
    end else begin
      seq_busy_prev_reg <= seq_busy;
      if (seq_busy_prev_reg && !seq_busy) begin
        seq_cnt_reg <= 5'(SEQ_PULSE_CYC);
      end else if (seq_cnt_reg != 5'h0) begin
        seq_cnt_reg <= seq_cnt_reg - 5'h1;
      end
    end
  end

  // Drivers are cut at once; status follows when the driver reports idle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spk_drive_en <= 1'b0;
      spk_sd_reg   <= 1'b0;
    end else begin
      spk_drive_en <= clk_ctrl_reg[CLK_SPK] & !spk_fault;
      spk_sd_reg   <= spk_fault & !spk_drive_en & spk_drive_idle;
    end
  end

  // Registered pin mux keeps the pins glitch free
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_out <= '0;
    end else begin
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_out[p] <= fn_level(pin_fn_reg[8*p +: 8], src);
      end
    end
  end

  assign main_clock_enable      = clk_ctrl_reg[CLK_MAIN];
  assign secondary_clock_enable = clk_ctrl_reg[CLK_SEC];
  assign fw_mem_clock_enable    = clk_ctrl_reg[CLK_FW];

  // Write address and data are taken in either order, then answered together
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_fw = awaddr_reg[11:4] == FW_PAGE;
  assign wr_ok = addr_ok(awaddr_reg) && !(wr_fw && !clk_ctrl_reg[CLK_FW]);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_reg    <= 12'h0;
      wdata_reg     <= 32'h0;
      wstrb_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_reg    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control registers; the host must not write again while a clock winds down
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_fn_reg   <= RST_PIN_FN;
      rate_reg     <= RST_RATE;
      isochronous_rate_converter_reg     <= RST_ISOCHRONOUS_RATE_CONVERTER;
      clk_ctrl_reg <= RST_CLK;
    end else if (wr_go && wr_ok) begin
      unique case (awaddr_reg)
        ADDR_PIN_FN: pin_fn_reg <= merge(pin_fn_reg, wdata_reg, wstrb_reg);
        ADDR_RATE:   rate_reg   <= merge(rate_reg, wdata_reg, wstrb_reg);
        ADDR_ISOCHRONOUS_RATE_CONVERTER:   isochronous_rate_converter_reg   <= merge(isochronous_rate_converter_reg, wdata_reg, wstrb_reg);
        ADDR_CLK:    clk_ctrl_reg <= wstrb_reg[0] ? wdata_reg[3:0] : clk_ctrl_reg;
        default:     clk_ctrl_reg <= clk_ctrl_reg;
      endcase
    end
  end

  // Firmware memory, reachable only while its clock runs
  always_ff @(posedge sys_clk) begin
    if (wr_go && wr_ok && wr_fw && {1'b0, awaddr_reg[3:2]} < 3'(FW_WORDS)) begin
      fw_mem[awaddr_reg[3:2]] <= merge(fw_mem[awaddr_reg[3:2]], wdata_reg, wstrb_reg);
    end
  end

  // Read side answers on the same edge that takes the address
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_fw = s_axi_araddr[11:4] == FW_PAGE;
  assign rd_ok = addr_ok(s_axi_araddr) && !(rd_fw && !clk_ctrl_reg[CLK_FW]);

  always_comb begin
    rd_val = 32'h0;
    if (rd_fw) begin
      rd_val = fw_mem[s_axi_araddr[3:2]];
    end else begin
      case (s_axi_araddr)
        ADDR_PIN_FN: rd_val = pin_fn_reg;
        ADDR_RATE:   rd_val = rate_reg;
        ADDR_ISOCHRONOUS_RATE_CONVERTER:   rd_val = isochronous_rate_converter_reg;
        ADDR_CLK:    rd_val = {28'h0, clk_ctrl_reg};
        ADDR_FLAGS:  rd_val = {19'h0, flags_reg};
        ADDR_RAW:    rd_val = {18'h0, seq_busy, lvl};
        default:     rd_val = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_ok ? rd_val : 32'h0;
        s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // One-cycle error level for any failed access
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl_err_reg <= 1'b0;
    end else begin
      ctl_err_reg <= (wr_go && !wr_ok) || (rd_go && !rd_ok);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_async_rate_converter_flag;
    $rose(src.async_rate_converter_err) |=> flags_reg[FL_ASYNC_RATE_CONVERTER];
  endproperty
  a_async_rate_converter_flag: assert property (p_async_rate_converter_flag) else $error("async error flag not set");

  property p_async_rate_converter_pin;
    (pin_fn_reg[7:0] == FN_ASYNC_RATE_CONVERTER_ERR && $stable(pin_fn_reg)) |=> pin_out[0] == $past(src.async_rate_converter_err);
  endproperty
  a_async_rate_converter_pin: assert property (p_async_rate_converter_pin) else $error("pin does not follow async error");

  property p_isochronous_rate_converter_flag;
    $rose(isochronous_rate_converter_bad[2]) |=> flags_reg[FL_ISOCHRONOUS_RATE_CONVERTER+2];
  endproperty
  a_isochronous_rate_converter_flag: assert property (p_isochronous_rate_converter_flag) else $error("isochronous flag not set");

  property p_spk_off;
    spk_fault |=> !spk_drive_en;
  endproperty
  a_spk_off: assert property (p_spk_off) else $error("speaker left on during fault");

  property p_spk_sd;
    ((spk_fault && spk_drive_idle) [*2]) ##0 !spk_sd_reg |=> spk_sd_reg ##1 flags_reg[FL_SPKSD];
  endproperty
  a_spk_sd: assert property (p_spk_sd) else $error("speaker shutdown status missing");

  property p_hp_flag;
    $rose(|(prot.hp_short_pos | prot.hp_short_neg)) |=> flags_reg[FL_HPSC];
  endproperty
  a_hp_flag: assert property (p_hp_flag) else $error("headphone short flag not set");

  property p_temp_fall;
    $fell(prot.temp_warn) |=> flags_reg[FL_TWARN];
  endproperty
  a_temp_fall: assert property (p_temp_fall) else $error("warning fall edge lost");

  property p_seq_pulse;
    (seq_busy_prev_reg && !seq_busy) |=> src.seq_done [*8] ##1 flags_reg[FL_SEQ];
  endproperty
  a_seq_pulse: assert property (p_seq_pulse) else $error("completion pulse too short");

  property p_seq_end;
    (seq_cnt_reg == 5'h1 && !(seq_busy_prev_reg && !seq_busy)) |=> !src.seq_done;
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("completion pulse does not end");

  property p_ctl_err;
    $rose(s_axi_bvalid) && s_axi_bresp == RESP_SLVERR |-> ctl_err_reg ##1 flags_reg[FL_CTL];
  endproperty
  a_ctl_err: assert property (p_ctl_err) else $error("failed write not reported");

  property p_fw_off;
    (rd_go && rd_fw && !clk_ctrl_reg[CLK_FW]) |=> s_axi_rresp == RESP_SLVERR && ctl_err_reg;
  endproperty
  a_fw_off: assert property (p_fw_off) else $error("firmware read with clock off accepted");

  property p_main_off;
    $rose(main_clk_stopped) |=> flags_reg[FL_MAIN];
  endproperty
  a_main_off: assert property (p_main_off) else $error("main clock shutdown flag not set");

  property p_hold;
    1'b1 |=> ((($past(flags_reg) & ~$past(clr_vec)) & ~flags_reg) == '0);
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped without clear");

endmodule : sev_top
`default_nettype wire

// [inc/sev_pkg.sv]
// Shared constants and types for the status event source block
package sev_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_PIN_FN  = 12'h000;
  localparam logic [11:0] ADDR_RATE    = 12'h004;
  localparam logic [11:0] ADDR_ISOCHRONOUS_RATE_CONVERTER    = 12'h008;
  localparam logic [11:0] ADDR_CLK     = 12'h00c;
  localparam logic [11:0] ADDR_FLAGS   = 12'h010;
  localparam logic [11:0] ADDR_RAW     = 12'h014;
  localparam logic [7:0]  FW_PAGE      = 8'h10;
  localparam int          FW_WORDS     = 4;
  // Reset values
  localparam logic [31:0] RST_PIN_FN   = 32'h0;
  localparam logic [31:0] RST_RATE     = 32'h0;
  localparam logic [31:0] RST_ISOCHRONOUS_RATE_CONVERTER     = 32'h0;
  localparam logic [3:0]  RST_CLK      = 4'h0;
  // Clock control bits
  localparam int CLK_MAIN = 0;
  localparam int CLK_SEC  = 1;
  localparam int CLK_FW   = 2;
  localparam int CLK_SPK  = 3;
  // Rate limit of the async converter in kHz
  localparam logic [7:0] ASYNC_RATE_CONVERTER_MAX_KHZ = 8'h30;
  // Pin function codes
  localparam logic [7:0] FN_SEQ_DONE  = 8'h15;
  localparam logic [7:0] FN_CTL_ERR   = 8'h16;
  localparam logic [7:0] FN_ASYNC_RATE_CONVERTER_ERR  = 8'h1c;
  localparam logic [7:0] FN_DRC1      = 8'h1d;
  localparam logic [7:0] FN_DRC2      = 8'h22;
  localparam logic [7:0] FN_TEMP_WARN = 8'h2b;
  localparam logic [7:0] FN_TEMP_SHUT = 8'h2c;
  localparam logic [7:0] FN_MAIN_CLK  = 8'h4b;
  localparam logic [7:0] FN_SEC_CLK   = 8'h4c;
  localparam logic [7:0] FN_ISOCHRONOUS_RATE_CONVERTER      = 8'h4d;
  localparam logic [7:0] FN_SPK_SHORT = 8'h53;
  localparam logic [7:0] FN_HP_SHORT  = 8'h54;
  localparam logic [7:0] FN_SPK_SD    = 8'h5a;
  // Flag bit positions
  localparam int NUM_FLAGS = 13;
  localparam int FL_ASYNC_RATE_CONVERTER   = 0;
  localparam int FL_ISOCHRONOUS_RATE_CONVERTER   = 1;
  localparam int FL_TWARN  = 4;
  localparam int FL_TSHUT  = 5;
  localparam int FL_SPKSC  = 6;
  localparam int FL_HPSC   = 7;
  localparam int FL_SPKSD  = 8;
  localparam int FL_SEQ    = 9;
  localparam int FL_CTL    = 10;
  localparam int FL_MAIN   = 11;
  localparam int FL_SEC    = 12;
  localparam logic [12:0] BOTH_EDGES = 13'h0030;
  // Timing
  localparam int SYS_CLK_MHZ   = 125;
  localparam int SEQ_PULSE_NS  = 100;
  localparam int SEQ_PULSE_CYC = (SEQ_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       temp_warn;
    logic       temp_shut;
    logic [1:0] spk_short;
    logic [5:0] hp_short_pos;
    logic [5:0] hp_short_neg;
  } sev_prot_t;

  typedef struct packed {
    logic [4:0] drc1;
    logic [4:0] drc2;
  } sev_drc_t;

  typedef struct packed {
    logic       async_rate_converter_err;
    logic [2:0] isochronous_rate_converter_err;
    logic       temp_warn;
    logic       temp_shut;
    logic       spk_short;
    logic [5:0] hp_short;
    logic       spk_sd;
    logic       seq_done;
    logic       ctl_err;
    logic       main_sts;
    logic       sec_sts;
    sev_drc_t   dynamic_range_compressor;
  } sev_src_t;
endpackage : sev_pkg

// [tb/sev_plant.sv]
// Speaker driver and clock domain stand-in driving the block's status inputs
`timescale 1ns/100ps
`default_nettype none
module sev_plant #(
  parameter int DLY = 4
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic spk_drive_en,
  input  wire logic main_clock_enable,
  input  wire logic secondary_clock_enable,
  output logic      spk_drive_idle,
  output logic      main_clk_stopped,
  output logic      sec_clk_stopped
);
  logic [DLY-1:0] idle_sh;
  logic [DLY-1:0] main_sh;
  logic [DLY-1:0] sec_sh;
  // Shutdown takes a few cycles, so status lags the enable on purpose
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      idle_sh <= '1;
      main_sh <= '1;
      sec_sh  <= '1;
    end else begin
      idle_sh <= {idle_sh[DLY-2:0], ~spk_drive_en};
      main_sh <= {main_sh[DLY-2:0], ~main_clock_enable};
      sec_sh  <= {sec_sh[DLY-2:0], ~secondary_clock_enable};
    end
  end
  assign spk_drive_idle   = idle_sh[DLY-1];
  assign main_clk_stopped = main_sh[DLY-1];
  assign sec_clk_stopped  = sec_sh[DLY-1];
endmodule : sev_plant
`default_nettype wire

// [tb/status_event_sources_tb.sv]
// Self-checking bench for the status event source block
`timescale 1ns/100ps
`default_nettype none
module status_event_sources_tb;
  import sev_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] awaddr  = '0;
  logic [11:0] araddr  = '0;
  logic [31:0] wdata   = '0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp, pin_out;
  logic [31:0] rdata, rd_d;
  sev_prot_t   prot = '0;
  sev_drc_t    dynamic_range_compressor = '0;
  sev_drc_t    dt;
  logic        seq_busy = 1'b0;
  logic        main_stop, sec_stop, spk_idle, spk_en, main_en, sec_en, fw_en;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cnt, n;

  always #4 sys_clk = ~sys_clk;

  sev_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .prot(prot), .dynamic_range_compressor(dynamic_range_compressor),
    .seq_busy(seq_busy), .main_clk_stopped(main_stop), .sec_clk_stopped(sec_stop),
    .spk_drive_idle(spk_idle), .pin_out(pin_out), .spk_drive_en(spk_en), .main_clock_enable(main_en),
    .secondary_clock_enable(sec_en), .fw_mem_clock_enable(fw_en));

  sev_plant plant_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .spk_drive_en(spk_en),
    .main_clock_enable(main_en), .secondary_clock_enable(sec_en), .spk_drive_idle(spk_idle),
    .main_clk_stopped(main_stop), .sec_clk_stopped(sec_stop));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (i == 100) n_fail++;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    int i;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (i == 100) n_fail++;
  endtask : rd

  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_d & m, e);
  endtask : rchk

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(ADDR_PIN_FN, '1, RST_PIN_FN);
    rchk(ADDR_RATE, '1, RST_RATE);
    rchk(ADDR_ISOCHRONOUS_RATE_CONVERTER, '1, RST_ISOCHRONOUS_RATE_CONVERTER);
    rchk(ADDR_CLK, 32'hf, 32'(RST_CLK));
    wr(ADDR_FLAGS, 32'h1fff);
    rchk(ADDR_FLAGS, 32'h1fff, 32'h0);
    // Async converter: 48 kHz is legal, 49 kHz is not
    wr(ADDR_PIN_FN, 32'(FN_ASYNC_RATE_CONVERTER_ERR));
    wr(ADDR_RATE, 32'h3030);
    cyc(4);
    rchk(ADDR_RAW, 32'h1, 32'h0);
    wr(ADDR_RATE, 32'h3130);
    cyc(4);
    chk(32'(pin_out[0]), 32'h1);
    rchk(ADDR_FLAGS, 32'h1, 32'h1);
    wr(ADDR_RATE, 32'h0);
    cyc(4);
    rchk(ADDR_FLAGS, 32'h1, 32'h1);
    wr(ADDR_FLAGS, 32'h1);
    rchk(ADDR_FLAGS, 32'h1, 32'h0);
    // Each isochronous converter with fast below slow
    for (n = 0; n < 3; n++) begin
      wr(ADDR_PIN_FN, 32'(FN_ISOCHRONOUS_RATE_CONVERTER) + 32'(n));
      wr(ADDR_ISOCHRONOUS_RATE_CONVERTER, 32'h21 << (8 * n));
      cyc(4);
      chk(32'(pin_out[0]), 32'h1);
      rchk(ADDR_FLAGS, 32'he, 32'h2 << n);
      wr(ADDR_ISOCHRONOUS_RATE_CONVERTER, 32'h0);
      wr(ADDR_FLAGS, 32'he);
    end
    // Compressor codes: pin 1 watches the neighbouring code, which stays low
    for (n = 0; n < 10; n++) begin
      dt = '0;
      if (n < 5) dt.drc1[n] = 1'b1;
      else dt.drc2[n-5] = 1'b1;
      dynamic_range_compressor <= dt;
      wr(ADDR_PIN_FN, {16'h0, FN_DRC1 + 8'(n + 1), FN_DRC1 + 8'(n)});
      cyc(3);
      chk(32'(pin_out), 32'h1);
    end
    dynamic_range_compressor <= '0;
    // Overheat shutdown turns the speaker off, then shutdown status follows
    wr(ADDR_CLK, 32'h8);
    wr(ADDR_PIN_FN, {16'h0, FN_SPK_SD, FN_TEMP_SHUT});
    wr(ADDR_FLAGS, 32'h1fff);
    chk(32'(spk_en), 32'h1);
    prot.temp_shut <= 1'b1;
    cyc(12);
    chk(32'(spk_en), 32'h0);
    chk(32'(pin_out), 32'h3);
    rchk(ADDR_FLAGS, 32'h120, 32'h120);
    wr(ADDR_FLAGS, 32'h1fff);
    prot.temp_shut <= 1'b0;
    cyc(8);
    chk(32'(spk_en), 32'h1);
    rchk(ADDR_FLAGS, 32'h20, 32'h20);
    wr(ADDR_PIN_FN, 32'(FN_TEMP_WARN));
    prot.temp_warn <= 1'b1;
    cyc(4);
    chk(32'(pin_out[0]), 32'h1);
    rchk(ADDR_FLAGS, 32'h10, 32'h10);
    prot <= '{spk_short: 2'b10, default: '0};
    cyc(4);
    chk(32'(spk_en), 32'h0);
    rchk(ADDR_FLAGS, 32'h40, 32'h40);
    // Headphone shorts, positive on even channels and negative on odd
    for (n = 0; n < 6; n++) begin
      prot <= '0;
      wr(ADDR_PIN_FN, 32'(FN_HP_SHORT) + 32'(n));
      if (n % 2 == 0) prot.hp_short_pos <= 6'(1 << n);
      else prot.hp_short_neg <= 6'(1 << n);
      cyc(4);
      chk(32'(pin_out[0]), 32'h1);
    end
    rchk(ADDR_FLAGS, 32'h80, 32'h80);
    prot <= '0;
    // Sequencer busy, then completion pulse width
    wr(ADDR_PIN_FN, 32'(FN_SEQ_DONE));
    wr(ADDR_FLAGS, 32'h1fff);
    seq_busy <= 1'b1;
    cyc(3);
    rchk(ADDR_RAW, 32'h2000, 32'h2000);
    rchk(ADDR_FLAGS, 32'h200, 32'h0);
    seq_busy <= 1'b0;
    cnt = 0;
    repeat (30) begin
      @(posedge sys_clk);
      if (pin_out[0] === 1'b1) cnt++;
    end
    chk(32'(cnt), 32'(SEQ_PULSE_CYC));
    rchk(ADDR_FLAGS, 32'h200, 32'h200);
    rchk(ADDR_RAW, 32'h2000, 32'h0);
    // Unmapped accesses and firmware memory with its clock off
    wr(ADDR_FLAGS, 32'h1fff);
    rd(12'h020);
    chk(32'(resp), 32'(RESP_SLVERR));
    rchk(ADDR_FLAGS, 32'h400, 32'h400);
    wr(12'h020, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    rd(12'h100);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(ADDR_CLK, 32'h4);
    wr(12'h104, 32'h5a5aa5a5);
    chk(32'(resp), 32'(RESP_OKAY));
    rd(12'h104);
    chk(rd_d, 32'h5a5aa5a5);
    // Clock domains on, then off with the host waiting for shutdown
    wr(ADDR_CLK, 32'h3);
    chk(32'({fw_en, sec_en, main_en}), 32'h3);
    wr(ADDR_PIN_FN, {16'h0, FN_SEC_CLK, FN_MAIN_CLK});
    cyc(8);
    chk(32'(pin_out), 32'h3);
    wr(ADDR_FLAGS, 32'h1fff);
    wr(ADDR_CLK, 32'h0);
    rd_d = '0;
    for (n = 0; n < 50 && rd_d[12:11] !== 2'b11; n++) rd(ADDR_FLAGS);
    chk(32'(rd_d[12:11]), 32'h3);
    chk(32'(pin_out), 32'h0);
    finish_test();
  end
endmodule : status_event_sources_tb
`default_nettype wire
